// File: rtl/owdc_lpf.sv
// first-order low-pass filter that averages the gated full-scale reference
// assumes x_i is a level sampled every enabled cycle
`timescale 1ns/1ps
module owdc_lpf #(
  parameter int W = 8,
  parameter int K = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic         clr_i,
  input  wire logic [W-1:0] x_i,
  output logic      [W-1:0] y_o
);

  logic        [W+K-1:0] acc_ff;
  logic signed [W+K:0]   diff;
  logic signed [W+K:0]   step;

  // ==========================================================================
  // step of 1/2^K toward the input, at least one lsb so dc settles exactly
  always_comb begin
    diff = $signed({1'b0, x_i, {K{1'b0}}}) - $signed({1'b0, acc_ff});
    step = diff >>> K;
    if (step == '0 && diff != '0) begin
      step = diff[W+K] ? '1 : (W+K+1)'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_ff <= '0;
    end else if (ce_i) begin
      acc_ff <= clr_i ? '0 : (W+K)'(acc_ff + step[W+K-1:0]);
    end
  end

  assign y_o = acc_ff[W+K-1:K];

endmodule

// File: rtl/owdc_pkg.sv
// constants, types and helper functions of the one-wire dimming control block
// assumes a single 100 MHz clock domain shared by every user of this package
package owdc_pkg;

  // ==========================================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US     = 1000;
  localparam int SHUT_TIME_US  = 2500;  // continuous low before shutdown
  localparam int DET_DELAY_US  = 100;   // mode_detect_delay
  localparam int DET_LOW_US    = 260;   // mode_detect_low_time
  localparam int DET_WIN_US    = 1000;  // mode_detect_window
  localparam int PHASE_MAX_US  = 360;   // longest bit, also longest phase
  localparam int SHORT_MAX_US  = 180;   // longest short phase of a bit
  localparam int ACK_TIME_US   = 400;   // length of the acknowledge pull-down

  // least times round up, longest times round down
  localparam int SHUT_CYC  = (SHUT_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_CYC   = (DET_DELAY_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DET_CYC   = (DET_LOW_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIN_CYC   = (DET_WIN_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int PH_CYC    = (PHASE_MAX_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int SHORT_CYC = (SHORT_MAX_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int ACK_CYC   = (ACK_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CW = 20;
  typedef logic [CW-1:0] owdc_cnt_t;

  // ==========================================================================
  // frame layout and brightness
  localparam int          ACK_REQ_BIT   = 7;
  localparam int          SEL_HI_BIT    = 6;
  localparam int          SEL_LO_BIT    = 5;
  localparam int          BRIGHT_MSB    = 4;
  localparam logic [4:0]  CODE_DEFAULT  = 5'h1F;
  localparam logic [7:0]  FULL_SCALE_MV = 8'hC8;
  localparam logic [4:0]  SEG1_LAST     = 5'h0C;
  localparam logic [4:0]  SEG2_LAST     = 5'h17;
  localparam logic [9:0]  SEG1_SLOPE    = 10'h003;
  localparam logic [9:0]  SEG1_OFS      = 10'h002;
  localparam logic [9:0]  SEG2_SLOPE    = 10'h006;
  localparam logic [9:0]  SEG2_OFS      = 10'h022;
  localparam logic [9:0]  SEG3_SLOPE    = 10'h00C;
  localparam logic [9:0]  SEG3_OFS      = 10'h0AC;

  // ==========================================================================
  // register map and fields
  localparam logic [3:0]  ADR_CTRL      = 4'h0;
  localparam logic [3:0]  ADR_STATUS    = 4'h4;
  localparam logic [3:0]  ADR_LEVEL     = 4'h8;
  localparam int          CTRL_ACK_EN   = 0;
  localparam int          CTRL_FORCE    = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h1;
  localparam int          LEVEL_REF_LSB = 8;

  // ==========================================================================
  // operating states, gray along off, delay, window, one-wire
  typedef enum logic [2:0] {
    ST_OFF    = 3'h0,
    ST_DELAY  = 3'h1,
    ST_WINDOW = 3'h3,
    ST_ONEW   = 3'h2,
    ST_PWM    = 3'h7
  } owdc_state_t;

  // saturating counter step
  function automatic owdc_cnt_t sat_inc(input owdc_cnt_t v);
    return (&v) ? v : owdc_cnt_t'(v + 1'b1);
  endfunction

  // brightness code to reference level in mV
  function automatic logic [7:0] level_mv(input logic [4:0] c);
    logic [9:0] c10;
    c10 = {5'h00, c};
    if (c == 5'h00) return 8'h00;
    else if (c <= SEG1_LAST) return 8'(c10 * SEG1_SLOPE + SEG1_OFS);
    else if (c <= SEG2_LAST) return 8'(c10 * SEG2_SLOPE - SEG2_OFS);
    else return 8'(c10 * SEG3_SLOPE - SEG3_OFS);
  endfunction

endpackage

// File: rtl/owdc_sync.sv
// two-stage synchroniser for the control pin
// assumes the pin is asynchronous to clk_i and may change at any time
`timescale 1ns/1ps
module owdc_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_ff;
  logic q_ff;

  // ==========================================================================
  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= 1'b0;
      q_ff    <= 1'b0;
    end else if (ce_i) begin
      meta_ff <= d_i;
      q_ff    <= meta_ff;
    end
  end

  assign q_o = q_ff;

endmodule

// File: rtl/owdc_top.sv
// control logic behind the single control pin of an led backlight driver
// assumes fault flags and wishbone signals are synchronous to clk_i, the pin is synchronised here
// What this block does
// - low over 2.5 ms shuts down switching
// - steady high gives 200 mV full scale
// - pwm gates full scale, then low-pass filters
// - one command selects any of 32 steps
// - code maps piecewise 3, 6, 12 mV steps
// - each start-up selects code 31, 200 mV
// - code held internally, reset restores full scale
// - host starts every transfer, device only answers
// - address byte then data byte, own address
// - data byte: five code, two select, ack
// - acknowledge requested bit drives acknowledge after frame
// - only correct frames are acknowledged
// - bits by relative durations, 2.8 to 160 kbit/s
// - undervoltage forces shutdown, restarts when cleared
// - over-temperature forces shutdown, restarts when cleared
// - one-wire chosen only at start-up window
// - bit ratio two to one, 360 us limit
// - data bit order: ack, selects, code msb first
// - acknowledge pulls pin low through open drain
`timescale 1ns/1ps
module owdc_top #(
  parameter int         SHUT_CYC  = owdc_pkg::SHUT_CYC,
  parameter int         DLY_CYC   = owdc_pkg::DLY_CYC,
  parameter int         DET_CYC   = owdc_pkg::DET_CYC,
  parameter int         WIN_CYC   = owdc_pkg::WIN_CYC,
  parameter int         PH_CYC    = owdc_pkg::PH_CYC,
  parameter int         SHORT_CYC = owdc_pkg::SHORT_CYC,
  parameter int         ACK_CYC   = owdc_pkg::ACK_CYC,
  parameter int         LPF_K     = 16,
  parameter logic [7:0] DEV_ADDR  = 8'hA5  // arbitrary value
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        ctrl_pin_i,
  output logic             ctrl_pin_o,
  output logic             ctrl_pin_oe_o,
  input  wire logic        uvlo_i,
  input  wire logic        otp_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             switch_en_o,
  output logic [7:0]       feedback_reference_o
);

  localparam int CW = owdc_pkg::CW;
  localparam owdc_pkg::owdc_cnt_t SHUT_C  = owdc_pkg::owdc_cnt_t'(SHUT_CYC);
  localparam owdc_pkg::owdc_cnt_t DLY_C   = owdc_pkg::owdc_cnt_t'(DLY_CYC);
  localparam owdc_pkg::owdc_cnt_t DET_C   = owdc_pkg::owdc_cnt_t'(DET_CYC);
  localparam owdc_pkg::owdc_cnt_t WIN_C   = owdc_pkg::owdc_cnt_t'(WIN_CYC);
  localparam owdc_pkg::owdc_cnt_t PH_C    = owdc_pkg::owdc_cnt_t'(PH_CYC);
  localparam owdc_pkg::owdc_cnt_t SHORT_C = owdc_pkg::owdc_cnt_t'(SHORT_CYC);
  localparam owdc_pkg::owdc_cnt_t ACK_C   = owdc_pkg::owdc_cnt_t'(ACK_CYC - 1);
  localparam owdc_pkg::owdc_cnt_t LO_IDLE = owdc_pkg::owdc_cnt_t'(PH_CYC + 1);

  owdc_pkg::owdc_state_t state_ff;
  owdc_pkg::owdc_state_t nxt_state;
  owdc_pkg::owdc_cnt_t   low_run_ff;
  owdc_pkg::owdc_cnt_t   tmr_ff;
  owdc_pkg::owdc_cnt_t   det_ff;
  owdc_pkg::owdc_cnt_t   lo_cnt_ff;
  owdc_pkg::owdc_cnt_t   hi_cnt_ff;
  owdc_pkg::owdc_cnt_t   ack_cnt_ff;
  logic                  pin_s;
  logic                  pin_d_ff;
  logic                  fall;
  logic                  rise;
  logic                  shut_hit;
  logic                  force_off;
  logic                  start;
  logic                  switch_ff;
  logic                  have_lo_ff;
  logic                  bad_ff;
  logic [4:0]            nbits_ff;
  logic [15:0]           shreg_ff;
  logic [15:0]           word;
  logic [1:0]            dec;
  logic                  frame_done;
  logic                  frame_ok;
  logic                  ack_ff;
  logic [4:0]            code_ff;
  logic [7:0]            ref_ff;
  logic [7:0]            lpf_y;
  logic [1:0]            ctrl_ff;
  logic                  wb_ack_ff;
  logic [31:0]           wb_dat_ff;
  logic                  wb_req;

  // ==========================================================================
  // pin conditioning
  // the raw pin is timed only after two flip-flops
  owdc_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (ctrl_pin_i),
    .q_o   (pin_s)
  );

  // previous synchronised level for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_d_ff <= 1'b0;
    end else if (ce_i) begin
      pin_d_ff <= pin_s;
    end
  end

  assign fall = pin_d_ff & ~pin_s;
  assign rise = ~pin_d_ff & pin_s;

  // ==========================================================================
  // shutdown and start-up mode selection
  // consecutive low time, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_run_ff <= '0;
    end else if (ce_i) begin
      low_run_ff <= pin_s ? '0 : owdc_pkg::sat_inc(low_run_ff);
    end
  end

  assign shut_hit  = ~pin_s && low_run_ff >= SHUT_C;
  // faults and software hold the device off while they last
  assign force_off = shut_hit | uvlo_i | otp_i | ctrl_ff[owdc_pkg::CTRL_FORCE];
  assign start     = ~force_off & pin_s;

  // next operating state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      owdc_pkg::ST_OFF: begin
        if (start) nxt_state = owdc_pkg::ST_DELAY;
      end
      owdc_pkg::ST_DELAY: begin
        if (tmr_ff >= DLY_C) nxt_state = owdc_pkg::ST_WINDOW;
      end
      owdc_pkg::ST_WINDOW: begin
        if (~pin_s && det_ff >= DET_C) nxt_state = owdc_pkg::ST_ONEW;
        else if (tmr_ff >= WIN_C) nxt_state = owdc_pkg::ST_PWM;
      end
      owdc_pkg::ST_ONEW,
      owdc_pkg::ST_PWM: nxt_state = state_ff;
      default: nxt_state = owdc_pkg::ST_OFF;
    endcase
    if (force_off) nxt_state = owdc_pkg::ST_OFF;
  end

  // state and switch enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff  <= owdc_pkg::ST_OFF;
      switch_ff <= 1'b0;
    end else if (ce_i) begin
      state_ff  <= nxt_state;
      switch_ff <= nxt_state != owdc_pkg::ST_OFF;
    end
  end

  // time since enable; low time inside the detection window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_ff <= '0;
      det_ff <= '0;
    end else if (ce_i) begin
      tmr_ff <= (state_ff == owdc_pkg::ST_OFF) ? '0 : owdc_pkg::sat_inc(tmr_ff);
      if (state_ff != owdc_pkg::ST_WINDOW || pin_s) det_ff <= '0;
      else det_ff <= owdc_pkg::sat_inc(det_ff);
    end
  end

  // ==========================================================================
  // bit decoding by relative phase lengths, no fixed bit period
  function automatic logic [1:0] bit_decode(input owdc_pkg::owdc_cnt_t lo, input owdc_pkg::owdc_cnt_t hi);
    logic [CW:0] sum;
    logic        one;
    logic        zero;
    sum  = {1'b0, lo} + {1'b0, hi};
    one  = ({1'b0, hi} >= {lo, 1'b0}) && lo <= SHORT_C;
    zero = ({1'b0, lo} >= {hi, 1'b0}) && hi <= SHORT_C;
    return {(sum <= {1'b0, PH_C}) && (one || zero), one};
  endfunction

  // a bit is a low phase then a high phase, closed by the next fall
  always_comb begin
    dec        = bit_decode(lo_cnt_ff, hi_cnt_ff);
    word       = {shreg_ff[14:0], dec[0]};
    frame_done = ce_i && state_ff == owdc_pkg::ST_ONEW && ~ack_ff && fall && have_lo_ff && nbits_ff == 5'h0F;
    frame_ok   = frame_done && ~bad_ff && dec[1] && word[15:8] == DEV_ADDR
                 && ~word[owdc_pkg::SEL_HI_BIT] && ~word[owdc_pkg::SEL_LO_BIT];
  end

  // phase counters, shift register and frame progress
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lo_cnt_ff  <= LO_IDLE;
      hi_cnt_ff  <= '0;
      have_lo_ff <= 1'b0;
      nbits_ff   <= 5'h00;
      bad_ff     <= 1'b0;
      shreg_ff   <= 16'h0000;
    end else if (ce_i) begin
      if (state_ff != owdc_pkg::ST_ONEW || ack_ff) begin
        lo_cnt_ff  <= LO_IDLE;
        hi_cnt_ff  <= '0;
        have_lo_ff <= 1'b0;
        nbits_ff   <= 5'h00;
        bad_ff     <= 1'b0;
      end else if (fall) begin
        if (have_lo_ff) begin
          shreg_ff <= word;
          if (frame_done) begin
            nbits_ff <= 5'h00;
            bad_ff   <= 1'b0;
          end else begin
            nbits_ff <= 5'(nbits_ff + 5'h01);
            bad_ff   <= bad_ff | ~dec[1];
          end
        end
        lo_cnt_ff  <= frame_done ? LO_IDLE : owdc_pkg::owdc_cnt_t'(1);
        hi_cnt_ff  <= '0;
        have_lo_ff <= 1'b0;
      end else if (~pin_s) begin
        lo_cnt_ff <= owdc_pkg::sat_inc(lo_cnt_ff);
        // an overlong low abandons the frame
        if (lo_cnt_ff == PH_C) begin
          nbits_ff <= 5'h00;
          bad_ff   <= 1'b0;
        end
      end else if (rise) begin
        have_lo_ff <= lo_cnt_ff <= PH_C;
        hi_cnt_ff  <= owdc_pkg::owdc_cnt_t'(1);
      end else begin
        hi_cnt_ff <= owdc_pkg::sat_inc(hi_cnt_ff);
        // idle high: any partial frame is dropped, host restarts it
        if (have_lo_ff && hi_cnt_ff == PH_C) begin
          nbits_ff   <= 5'h00;
          bad_ff     <= 1'b0;
          have_lo_ff <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // brightness code
  // restored to full scale on every start-up and on reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_ff <= owdc_pkg::CODE_DEFAULT;
    end else if (ce_i) begin
      if (state_ff == owdc_pkg::ST_OFF && start) code_ff <= owdc_pkg::CODE_DEFAULT;
      else if (frame_ok) code_ff <= word[owdc_pkg::BRIGHT_MSB:0];
    end
  end

  // ==========================================================================
  // acknowledge: open-drain pull-down after an accepted frame
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff     <= 1'b0;
      ack_cnt_ff <= '0;
    end else if (ce_i) begin
      if (frame_ok && word[owdc_pkg::ACK_REQ_BIT] && ctrl_ff[owdc_pkg::CTRL_ACK_EN]) begin
        ack_ff     <= 1'b1;
        ack_cnt_ff <= '0;
      end else if (ack_ff) begin
        ack_cnt_ff <= owdc_pkg::sat_inc(ack_cnt_ff);
        if (ack_cnt_ff >= ACK_C || state_ff != owdc_pkg::ST_ONEW) ack_ff <= 1'b0;
      end
    end
  end

  assign ctrl_pin_o    = 1'b0;  // only ever pulls low
  assign ctrl_pin_oe_o = ack_ff;

  // ==========================================================================
  // feedback reference
  // pwm: full scale gated by the pin, then averaged
  owdc_lpf #(
    .W (8),
    .K (LPF_K)
  ) u_lpf (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .clr_i (state_ff == owdc_pkg::ST_OFF),
    .x_i   (pin_s ? owdc_pkg::FULL_SCALE_MV : 8'h00),
    .y_o   (lpf_y)
  );

  // reference level by mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_ff <= 8'h00;
    end else if (ce_i) begin
      unique case (state_ff)
        owdc_pkg::ST_OFF:  ref_ff <= 8'h00;
        owdc_pkg::ST_ONEW: ref_ff <= owdc_pkg::level_mv(code_ff);
        default:           ref_ff <= lpf_y;
      endcase
    end
  end

  assign feedback_reference_o = ref_ff;
  assign switch_en_o          = switch_ff;

  // ==========================================================================
  // wishbone slave, one wait state, unmapped reads return zero
  assign wb_req = wb_cyc_i & wb_stb_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_ff <= wb_req & ~wb_ack_ff;
      if (wb_req && !wb_ack_ff) begin
        unique case (wb_adr_i[3:2])
          owdc_pkg::ADR_CTRL[3:2]:   wb_dat_ff <= {30'h0000_0000, ctrl_ff};
          owdc_pkg::ADR_STATUS[3:2]: wb_dat_ff <= {26'h000_0000, switch_ff, otp_i, uvlo_i, state_ff};
          owdc_pkg::ADR_LEVEL[3:2]:  wb_dat_ff <= {16'h0000, ref_ff, 3'h0, code_ff};
          default:                   wb_dat_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control register, written at the acknowledging edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= owdc_pkg::CTRL_RESET;
    end else if (ce_i && wb_req && wb_we_i && wb_ack_ff && wb_sel_i[0]) begin
      if (wb_adr_i[3:2] == owdc_pkg::ADR_CTRL[3:2]) ctrl_ff <= wb_dat_i[1:0];
    end
  end

  assign wb_ack_o = wb_ack_ff;
  assign wb_dat_o = wb_dat_ff;

  // ==========================================================================
  // checks
  a_shutdown_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && shut_hit |=> state_ff == owdc_pkg::ST_OFF && !switch_en_o)
    else $error("low pin did not shut down");

  a_uvlo_off: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && uvlo_i |=> !switch_en_o && state_ff == owdc_pkg::ST_OFF
    ##1 (feedback_reference_o == 8'h00 || !$past(ce_i)))
    else $error("undervoltage did not stop switching");

  a_otp_off: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && otp_i |=> state_ff == owdc_pkg::ST_OFF)
    else $error("over-temperature did not shut down");

  a_start_default: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state_ff == owdc_pkg::ST_OFF && start |=> code_ff == 5'h1F && state_ff == owdc_pkg::ST_DELAY)
    else $error("start-up did not select full scale");

  a_level_map: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state_ff == owdc_pkg::ST_ONEW && code_ff == 5'h0D |=> feedback_reference_o == 8'h2C)
    else $error("code 13 did not give 44 mV");

  a_detect_onew: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state_ff == owdc_pkg::ST_WINDOW && !pin_s && det_ff >= DET_C && !force_off
    |=> state_ff == owdc_pkg::ST_ONEW)
    else $error("long low in window did not select one-wire");

  a_ack_valid: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(ctrl_pin_oe_o) |-> $past(frame_ok) && $past(word[7]))
    else $error("acknowledge without accepted frame");

  a_ack_request: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_ok && word[7] && ctrl_ff[0] |=> ctrl_pin_oe_o ##1 (ctrl_pin_oe_o || !ce_i))
    else $error("requested acknowledge not driven");

  a_sel_discard: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_done && word[6:5] != 2'b00 && state_ff != owdc_pkg::ST_OFF |=> $stable(code_ff))
    else $error("frame with nonzero select changed code");

endmodule

// File: test/owdc_host.sv
// host model: drives the control pin low or lets the pull-up raise it
// assumes the device pulls the pin only through its output enable
`timescale 1ns/1ps
module owdc_host (
  input  wire logic clk_i,
  input  wire logic dev_oe_i,
  output logic      pin_o
);
  logic host_low = 1'b0;
  // ==========
  // wire level, pulled up unless a party pulls low
  assign pin_o = !(host_low || dev_oe_i);
  // hold one level for n cycles, called just after an edge
  task automatic hold(input logic lvl, input int n);
    host_low <= !lvl;
    repeat (n) @(posedge clk_i);
  endtask
  // short phase 8, long phase 20 cycles
  task automatic bit_out(input logic b);
    hold(1'b0, b ? 8 : 20);
    hold(1'b1, b ? 20 : 8);
  endtask
  // host starts every frame, address then data msb first
  task automatic frame(input logic [7:0] a, input logic [7:0] d);
    for (int i = 15; i >= 0; i--) begin
      bit_out(i > 7 ? a[i-8] : d[i]);
    end
    hold(1'b0, 10);
    hold(1'b1, 80);
  endtask
endmodule

// File: test/owdc_top_tb_top.sv
// bench for the dimming control block, host model on the pin
// assumes shortened timing parameters set below
`timescale 1ns/1ps
module owdc_top_tb_top;
  localparam logic [7:0] ADDR = 8'h5C;  // arbitrary device address
  // shortened timing in cycles, only the real delay-to-window and phase ratios kept
  localparam int T_SHUT = 400, T_DLY = 20, T_DET = 40, T_WIN = 200, T_PH = 60, T_SHORT = 30, T_ACK = 50, T_K = 4;
  // hand-picked codes: segment ends and full scale
  localparam logic [29:0] CORNER = {5'h01, 5'h0C, 5'h0D, 5'h17, 5'h18, 5'h1F};
  logic clk = 1'b0, rst = 1'b1, uvlo = 1'b0, otp = 1'b0, pin, oe, sw, ack, we = 1'b0, cyc = 1'b0;
  logic ce = 1'b1, pdo;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wd = 32'h0, rd, q;
  logic [7:0] fb;
  logic [4:0] cur;
  int err_count = 0, total_checks = 0, acks = 0;
  // ==========
  always #5 clk = ~clk;
  // count cycles the device pulls the pin
  always @(posedge clk) if (oe === 1'b1) acks <= acks + 1;
  // a device driving high while enabled would hide the acknowledge
  owdc_host host (.clk_i(clk), .dev_oe_i(oe && !pdo), .pin_o(pin));
  owdc_top #(.SHUT_CYC(T_SHUT), .DLY_CYC(T_DLY), .DET_CYC(T_DET), .WIN_CYC(T_WIN), .PH_CYC(T_PH),
    .SHORT_CYC(T_SHORT), .ACK_CYC(T_ACK), .LPF_K(T_K), .DEV_ADDR(ADDR)) dut (.clk_i(clk), .rst_i(rst),
    .ce_i(ce), .ctrl_pin_i(pin), .ctrl_pin_o(pdo), .ctrl_pin_oe_o(oe), .uvlo_i(uvlo), .otp_i(otp),
    .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_dat_o(rd), .wb_ack_o(ack), .switch_en_o(sw), .feedback_reference_o(fb));
  // ==========
  // expected reference in mV for a code
  function automatic logic [7:0] lvl(input int c);
    if (c == 0) return 8'h00;
    if (c <= 12) return 8'(5 + 3 * (c - 1));
    if (c <= 23) return 8'(44 + 6 * (c - 13));
    return 8'(116 + 12 * (c - 24));
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    adr <= a;
    we <= w;
    wd <= d;
    sel <= 4'hF;
    cyc <= 1'b1;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rd;
    cyc <= 1'b0;
    @(posedge clk);
  endtask
  // send a frame, then check acknowledge, stored code and reference
  task automatic frm(input logic [7:0] a, input logic [7:0] d, input logic [4:0] c, input logic k);
    acks = 0;
    host.frame(a, d);
    chk("ack", {31'h0, k}, {31'h0, acks != 0});
    wb(4'h8, 1'b0, 32'h0, q);
    chk("code", {27'h0, c}, {27'h0, q[4:0]});
    chk("fb", {24'h0, lvl(c)}, {24'h0, fb});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========
  // watchdog, about four times the expected run
  initial begin
    #400000;
    err_count++;
    results();
  end
  // main sequence
  initial begin
    void'($urandom(9783));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wb(4'h0, 1'b0, 32'h0, q);
    chk("ctrl", 32'h1, q);
    wb(4'hC, 1'b1, 32'hFFFFFFFF, q);
    wb(4'hC, 1'b0, 32'h0, q);
    chk("hole", 32'h0, q);
    host.hold(1'b1, 30);
    chk("sw", 32'h1, {31'h0, sw});
    chk("drive", 32'h0, {31'h0, pdo});
    wb(4'h8, 1'b0, 32'h0, q);
    chk("code", 32'h1F, {27'h0, q[4:0]});
    host.hold(1'b0, 50);
    host.hold(1'b1, 10);
    wb(4'h4, 1'b0, 32'h0, q);
    chk("mode", 32'h2, {29'h0, q[2:0]});
    for (int i = 0; i < 10; i++) begin
      // codes never zero, so no step up from code zero
      cur = i < 6 ? CORNER[5*i +: 5] : 5'($urandom_range(1, 31));
      q[0] = 1'($urandom);
      frm(ADDR, {q[0], 2'h0, cur}, cur, q[0]);
    end
    frm(ADDR ^ 8'h01, 8'h85, cur, 1'b0);
    frm(ADDR, 8'hA5, cur, 1'b0);
    wb(4'h0, 1'b1, 32'h0, q);
    frm(ADDR, 8'h85, 5'h05, 1'b0);
    wb(4'h0, 1'b1, 32'h1, q);
    frm(ADDR, 8'h80, 5'h00, 1'b1);
    // code zero is left here through a shutdown and restart
    host.hold(1'b0, 390);
    chk("sw", 32'h1, {31'h0, sw});
    host.hold(1'b0, 30);
    chk("sw", 32'h0, {31'h0, sw});
    host.hold(1'b1, 300);
    wb(4'h8, 1'b0, 32'h0, q);
    chk("restart", 32'h1F, {27'h0, q[4:0]});
    chk("full", 32'hC8, {24'h0, fb});
    wb(4'h4, 1'b0, 32'h0, q);
    chk("mode", 32'h7, {29'h0, q[2:0]});
    // 20-cycle period at half duty, inside the scaled frequency band
    for (int i = 0; i < 20; i++) begin
      host.hold(1'b0, 10);
      host.hold(1'b1, 10);
    end
    chk("pwm", 32'h1, {31'h0, fb > 8'h3C && fb < 8'h8C});
    for (int i = 0; i < 2; i++) begin
      {otp, uvlo} <= 2'h1 << i;
      repeat (5) @(posedge clk);
      chk("fault", 32'h0, {31'h0, sw});
      wb(4'h4, 1'b0, 32'h0, q);
      chk("status", 32'h8 << i, q);
      {otp, uvlo} <= 2'h0;
      repeat (30) @(posedge clk);
      chk("resume", 32'h1, {31'h0, sw});
    end
    // software force-off holds the device down until cleared
    wb(4'h0, 1'b1, 32'h3, q);
    wb(4'h0, 1'b0, 32'h0, q);
    chk("ctrl", 32'h3, q);
    chk("force", 32'h0, {31'h0, sw});
    wb(4'h0, 1'b1, 32'h1, q);
    // clock enable low freezes everything, even a long low pin
    ce <= 1'b0;
    host.hold(1'b0, 450);
    chk("freeze", 32'h1, {31'h0, sw});
    ce <= 1'b1;
    host.hold(1'b0, 410);
    chk("sw", 32'h0, {31'h0, sw});
    results();
  end
endmodule
